//--- adc_conversion_sequencer.sv
/*
  converter sequencer: AHB-Lite register slave, conversion timing, done flag,
  interrupt request and channel locking. assumes the analog core presents its
  result code asynchronously and that trigger flags come from hclk logic.
*/
// Decided for this implementation: the AHB-Lite interface to the registers.
`include "adc_seq_defs.svh"
`default_nettype none
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int RESULT_W = 8
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] trigger_flags,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  input wire logic [RESULT_W-1:0] core_code,
  output logic core_power,
  output logic core_convert,
  output logic [1:0] core_channel,
  output logic irq
);

  ctl_state_t s;
  ctl_state_t next_s;
  logic tick;
  logic trig_event;
  logic presc_clear;
  logic wr;
  logic go_write;
  logic flag_write;
  logic start_req;
  logic done;
  logic free_run;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  if (RESULT_W != 8) begin : g_chk
    $error("result width must be 8");
  end

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  conv_prescaler #(
    .CNT_W(7)
  ) u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(presc_clear),
    .div_sel(s.div_sel),
    .tick(tick)
  );

  trigger_edge u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .flags(trigger_flags),
    .sel(s.trig_sel),
    .auto_on(s.auto_on),
    .event_pulse(trig_event)
  );

  // held off while disabled, restarted by a trigger so its delay is fixed
  assign presc_clear = !s.on || (trig_event && s.phase == PH_IDLE);

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    wr = s.ap_valid && s.ap_write;
    wbyte = hwdata[7:0];
    go_write = 1'b0;
    flag_write = 1'b0;
    free_run = s.auto_on && (s.trig_sel == `TRIG_FREE_RUN);
    done = (s.phase == PH_RUN) && tick && (s.cyc == 5'h00);
    rbyte = 8'h00;

    // bus address phase, zero wait states
    next_s.ap_valid = hsel && htrans[1] && hready;
    next_s.ap_write = hwrite;
    next_s.ap_idx = haddr[7:2];

    // data phase writes
    if (wr && s.ap_idx == `IDX_CONTROL)
    begin
      next_s.on = wbyte[`CTL_ON];
      next_s.auto_on = wbyte[`CTL_AUTO];
      next_s.irq_en = wbyte[`CTL_IRQ_EN];
      next_s.div_sel = wbyte[2:0];
      go_write = wbyte[`CTL_GO];
      flag_write = wbyte[`CTL_FLAG];
    end
    if (wr && s.ap_idx == `IDX_TRIGGER)
    begin
      next_s.trig_sel = wbyte[2:0];
    end
    if (wr && s.ap_idx == `IDX_CHANNEL)
    begin
      next_s.in_sel = wbyte[1:0];
    end

    // analog code synchroniser
    next_s.code_s1 = core_code;
    next_s.code_s2 = s.code_s1;

    // conversion sequence
    start_req = next_s.on && (go_write || (s.on && trig_event));
    case (s.phase)
      PH_IDLE:
      begin
        if (start_req)
        begin
          next_s.phase = PH_ARMED;
          next_s.go = 1'b1;
        end
      end
      PH_ARMED:
      begin
        if (tick)
        begin
          // begins on the next converter clock edge
          next_s.phase = PH_RUN;
          next_s.conv_run = 1'b1;
          next_s.cyc = s.first ? (`FIRST_CONV_CYCLES - 5'h01)
                               : (`NORMAL_CONV_CYCLES - 5'h01);
          next_s.first = 1'b0;
        end
      end
      PH_RUN:
      begin
        if (done)
        begin
          next_s.result = s.code_s2;
          if (free_run)
          begin
            // restarts regardless of the done flag state
            next_s.cyc = `NORMAL_CONV_CYCLES - 5'h01;
          end
          else
          begin
            next_s.phase = PH_IDLE;
            next_s.conv_run = 1'b0;
            next_s.go = 1'b0;
          end
        end
        else if (tick)
        begin
          next_s.cyc = s.cyc - 5'h01;
        end
      end
      default:
      begin
        next_s.phase = PH_IDLE;
      end
    endcase

    // turning off aborts and re-arms the long first conversion
    if (!next_s.on)
    begin
      next_s.phase = PH_IDLE;
      next_s.conv_run = 1'b0;
      next_s.go = 1'b0;
      next_s.first = 1'b1;
    end

    // channel follows the field except while a conversion is locked
    if (s.phase != PH_RUN || s.cyc == 5'h00)
    begin
      next_s.active_ch = s.in_sel;
    end

    // the set wins over both clears
    if (flag_write || irq_vector_ack)
    begin
      next_s.flag = 1'b0;
    end
    if (done)
    begin
      next_s.flag = 1'b1;
    end

    next_s.irq = next_s.flag && next_s.irq_en && global_irq_enable;

    // read data for the next data phase, showing this cycle's writes
    case (haddr[7:2])
      `IDX_CONTROL: rbyte = {next_s.on, next_s.go, next_s.auto_on, next_s.flag,
                             next_s.irq_en, next_s.div_sel};
      `IDX_TRIGGER: rbyte = {5'h00, next_s.trig_sel};
      `IDX_CHANNEL: rbyte = {6'h00, next_s.in_sel};
      `IDX_RESULT: rbyte = next_s.result;
      default: rbyte = 8'h00;
    endcase
    next_s.rdata = (next_s.ap_valid && !hwrite) ? {24'h000000, rbyte} : 32'h00000000;
    next_s.ready = 1'b1;
    next_s.resp = 1'b0;
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.first <= 1'b1;
      s.ready <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign hreadyout = s.ready;
  assign hresp = s.resp;
  assign hrdata = s.rdata;
  assign core_power = s.on;
  assign core_convert = s.conv_run;
  assign core_channel = s.active_ch;
  assign irq = s.irq;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence seq_done;
    (s.phase == PH_RUN) && tick && (s.cyc == 5'h00);
  endsequence

  sequence seq_launch_first;
    (s.phase == PH_ARMED) && tick && s.first && s.on;
  endsequence

  sequence seq_launch_normal;
    (s.phase == PH_ARMED) && tick && !s.first && s.on;
  endsequence

  a_off_aborts: assert property (!s.on |-> (s.phase == PH_IDLE) && !s.go)
    else $error("conversion alive while converter off");

  a_go_busy: assert property ((s.phase != PH_IDLE) |-> s.go)
    else $error("convert-go low during conversion");

  a_first_len: assert property (seq_launch_first |=> (s.cyc == 5'h18))
    else $error("first conversion length wrong");

  a_normal_len: assert property (seq_launch_normal |=> (s.cyc == 5'h0c))
    else $error("normal conversion length wrong");

  a_done_sets: assert property (seq_done |=> s.flag && (s.result == $past(s.code_s2)))
    else $error("done flag or result not updated");

  a_irq_gate: assert property (##1 (s.irq == (s.flag && s.irq_en && $past(global_irq_enable))))
    else $error("interrupt request gating wrong");

  a_ack_clears: assert property (irq_vector_ack && !done |=> !s.flag)
    else $error("done flag survived vector acknowledge");

  a_chan_lock: assert property ((s.phase == PH_RUN) && (s.cyc != 5'h00)
    |=> s.active_ch == $past(s.active_ch))
    else $error("channel changed during conversion");

  a_trig_start: assert property (trig_event && s.on && (s.phase == PH_IDLE) && !go_write
    |=> (s.phase == PH_ARMED) || !s.on)
    else $error("trigger edge did not start a conversion");

  a_free_run: assert property (seq_done ##0 free_run ##0 next_s.on
    |=> (s.phase == PH_RUN) && s.go)
    else $error("free running sequence stopped");

  // -----------------------------------------------------------------
  // software-visible sequencing checks
  // -----------------------------------------------------------------
  sequence seq_ctl_write;
    wr && (s.ap_idx == `IDX_CONTROL);
  endsequence

  a_go_starts: assert property (go_write && next_s.on && (s.phase == PH_IDLE)
    |=> (s.phase == PH_ARMED) && s.go)
    else $error("convert-go write did not start a conversion");

  a_zero_ignored: assert property (seq_ctl_write ##0 (!wbyte[`CTL_GO] && !trig_event
    && (s.phase == PH_IDLE)) |=> (s.phase == PH_IDLE))
    else $error("zero convert-go write started a conversion");

  a_flag_w1c: assert property (seq_ctl_write ##0 (wbyte[`CTL_FLAG] && !done)
    |=> !s.flag)
    else $error("written one did not clear the done flag");

  a_launch_tick: assert property ((s.phase == PH_ARMED) && tick && next_s.on
    |=> (s.phase == PH_RUN) && s.conv_run)
    else $error("armed conversion missed its converter clock");

  a_cyc_count: assert property ((s.phase == PH_RUN) && tick && (s.cyc != 5'h00)
    |=> s.cyc == $past(s.cyc) - 5'h01)
    else $error("conversion counter skipped a converter clock");

  a_cyc_hold: assert property ((s.phase == PH_RUN) && !tick |=> $stable(s.cyc))
    else $error("conversion counter moved between converter clocks");

  a_trig_presc: assert property (trig_event && (s.phase == PH_IDLE) |=> !tick)
    else $error("trigger did not restart the prescaler");

  a_off_still: assert property (!s.on |-> !tick)
    else $error("converter clock ran while converter off");

  a_chan_follow: assert property ((s.phase == PH_IDLE)
    |=> s.active_ch == $past(s.in_sel))
    else $error("idle channel did not follow the input select field");

  a_result_hold: assert property (!done |=> $stable(s.result))
    else $error("result changed outside completion");

  a_flag_hold: assert property (!done && !flag_write && !irq_vector_ack
    |=> s.flag == $past(s.flag))
    else $error("done flag changed without a cause");

  a_auto_gate: assert property (!s.auto_on |-> !trig_event)
    else $error("trigger edge while auto-trigger off");

  a_free_quiet: assert property ((s.trig_sel == `TRIG_FREE_RUN) |-> !trig_event)
    else $error("free running selection made a trigger edge");

  a_single_stops: assert property (seq_done ##0 !free_run
    |=> (s.phase == PH_IDLE) && !s.go && !s.conv_run)
    else $error("single conversion did not stop at completion");

endmodule : adc_conversion_sequencer
`default_nettype wire

//--- adc_seq_defs.svh
/*
  register indices, field positions, reset values and conversion lengths for the
  converter sequencer. assumes inclusion by bare name from the design files.
*/
// Behaviour
// - converter-on powers up; clearing aborts conversion
// - convert-go write starts one or first conversion
// - first conversion 25 cycles, later ones 13
// - convert-go reads one while converting; zero ignored
// - auto-trigger starts conversion on source rising edge
// - done flag set when result updates
// - done flag cleared by vector or written one
// - interrupt needs flag, enable and global enable
// - divider select: 2,2,4,...,128
// - input select picks analog input 0..3
// - channel change waits for conversion end
// - trigger source ignored while auto-trigger off
// - trigger source code map 000..111
// - switching to a set source makes an edge
// - selecting free running makes no trigger
// - result code equals vin times 256 over vref
// - free running continues regardless of done flag
// - prescaler runs only while converter on
// - software start begins at next converter clock
// - trigger event resets the prescaler
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define IDX_RESULT 6'h19
`define IDX_CHANNEL 6'h1b
`define IDX_TRIGGER 6'h1c
`define IDX_CONTROL 6'h1d

// -----------------------------------------------------------------
// control and status fields
// -----------------------------------------------------------------
`define CTL_ON 7
`define CTL_GO 6
`define CTL_AUTO 5
`define CTL_FLAG 4
`define CTL_IRQ_EN 3
`define REG_RESET 8'h00
`define TRIG_FREE_RUN 3'h0

// -----------------------------------------------------------------
// conversion lengths in converter clock cycles
// -----------------------------------------------------------------
`define FIRST_CONV_CYCLES 5'h19
`define NORMAL_CONV_CYCLES 5'h0d

`endif

//--- adc_seq_pkg.sv
/*
  types shared by the sequencer modules.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package adc_seq_pkg;

  typedef enum logic [1:0] {PH_IDLE, PH_ARMED, PH_RUN} phase_t;

  typedef struct packed {
    logic on;
    logic go;
    logic auto_on;
    logic flag;
    logic irq_en;
    logic [2:0] div_sel;
    logic [2:0] trig_sel;
    logic [1:0] in_sel;
    logic [1:0] active_ch;
    logic [7:0] result;
    phase_t phase;
    logic [4:0] cyc;
    logic first;
    logic irq;
    logic conv_run;
    logic [7:0] code_s1;
    logic [7:0] code_s2;
    logic ap_valid;
    logic ap_write;
    logic [5:0] ap_idx;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } ctl_state_t;

  typedef struct packed {
    logic [6:0] count;
  } presc_state_t;

  typedef struct packed {
    logic prev;
  } edge_state_t;

endpackage : adc_seq_pkg
`default_nettype wire

//--- analog_core_model.sv
/*
  behavioural model of the analog multiplexer and converter core.
  assumes the sequencer holds core_channel steady until the last converter cycle of a conversion.
*/
`default_nettype none
module analog_core_model (
  input wire logic hclk,
  input wire logic power,
  input wire logic convert,
  input wire logic [1:0] channel,
  output logic [7:0] code
);
  timeunit 1ns;
  timeprecision 1ps;

  // -----------------------------------------------------------------
  // fixed input levels, one per analog input
  // -----------------------------------------------------------------
  // 0x00 is ground, 0xff is the reference less one step
  logic [7:0] level [4] = '{8'h00, 8'h55, 8'haa, 8'hff};
  logic [7:0] spin = 8'h3c;
  logic [7:0] held = 8'h00;

  // an unpowered core gives garbage that moves every cycle, never a held value;
  // the input is sampled before converting and held, so a channel change in the
  // last converter cycle cannot reach the result of the running conversion
  always @(posedge hclk)
  begin
    spin <= {spin[6:0], ~spin[7]};
    if (!convert)
    begin
      held <= level[channel];
    end
  end

  assign code = power ? held : spin;

endmodule : analog_core_model
`default_nettype wire

//--- conv_prescaler.sv
/*
  prescaler giving one-cycle converter clock enables from the system clock.
  assumes clear is held whenever the converter is off.
*/
`default_nettype none
module conv_prescaler
  import adc_seq_pkg::*;
#(
  parameter int CNT_W = 7
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic [2:0] div_sel,
  output logic tick
);

  presc_state_t s;
  presc_state_t next_s;
  logic [CNT_W-1:0] last;

  if (CNT_W < 7) begin : g_chk
    $error("prescaler counter too narrow for divide by 128");
  end

  // -----------------------------------------------------------------
  // divide by 2 for codes 0 and 1, doubling per code above
  // -----------------------------------------------------------------
  always_comb
  begin
    last = (div_sel <= 3'h1) ? CNT_W'(1) : CNT_W'((1 << div_sel) - 1);
    tick = !clear && (s.count == last[6:0]);
    next_s = s;
    if (clear || tick)
    begin
      next_s.count = 7'h00;
    end
    else
    begin
      next_s.count = s.count + 7'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  a_presc_held: assert property (@(posedge hclk) disable iff (!hresetn)
    clear |=> (s.count == 7'h00) && !tick)
    else $error("prescaler ran while cleared");

endmodule : conv_prescaler
`default_nettype wire

//--- tb_adc_conversion_sequencer.sv
/*
  self-checking bench for the converter sequencer over AHB-Lite.
  assumes a zero-wait slave, trigger flags on hclk and the analog core model.
*/
`include "adc_seq_defs.svh"
`default_nettype none
module tb_adc_conversion_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  // -----------------------------------------------------------------
  // stimulus and wiring
  // -----------------------------------------------------------------
  localparam logic [7:0] on_bit = 8'h80;
  localparam logic [7:0] go_bit = 8'h40;
  localparam logic [7:0] auto_bit = 8'h20;
  localparam logic [7:0] flag_bit = 8'h10;
  localparam logic [7:0] ie_bit = 8'h08;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] trigger_flags = 8'h00;
  logic global_irq_enable = 1'b0;
  logic irq_vector_ack = 1'b0;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [7:0] core_code;
  logic core_power;
  logic core_convert;
  logic [1:0] core_channel;
  logic irq;
  int checks = 0;
  int miscompares = 0;
  int n;
  logic [5:0] reset_idx [5] = '{`IDX_CHANNEL, `IDX_TRIGGER, `IDX_CONTROL, `IDX_RESULT, 6'h3f};

  always #4 hclk = ~hclk;
  assign hready = hreadyout;

  adc_conversion_sequencer DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trigger_flags(trigger_flags),
    .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
    .core_code(core_code), .core_power(core_power), .core_convert(core_convert),
    .core_channel(core_channel), .irq(irq)
  );

  analog_core_model core (.hclk(hclk), .power(core_power), .convert(core_convert),
    .channel(core_channel), .code(core_code));

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask : check

  function automatic logic near(input int got, input int exp);
    return got >= exp - 2 && got <= exp + 2;
  endfunction : near

  task automatic await_ready;
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1)
    begin
      miscompares++;
      end_of_test();
    end
  endtask : await_ready

  // called just after a rising edge; holds each phase until hready is seen high
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    await_ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    await_ready();
    rd = hrdata[7:0];
    check("hresp", 8'(hresp), 8'h00);
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [7:0] unused;
    bus(1'b1, idx, wd, unused);
  endtask : wr

  task automatic rd_chk(input string what, input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] got;
    bus(1'b0, idx, 8'h00, got);
    check(what, got, exp);
  endtask : rd_chk

  // counts cycles until core_convert equals v; running out of cycles ends the run
  task automatic wait_conv(input logic v, input int lim, output int cnt);
    cnt = 0;
    while (core_convert !== v && cnt < lim)
    begin
      @(posedge hclk);
      cnt++;
    end
    check("core_convert", 8'(core_convert), {7'h0, v});
    if (core_convert !== v)
    begin
      end_of_test();
    end
  endtask : wait_conv

  task automatic conv_len(output int cnt);
    int d;
    wait_conv(1'b1, 300, d);
    wait_conv(1'b0, 4000, cnt);
  endtask : conv_len

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (reset_idx[i]) rd_chk("reset value", reset_idx[i], 8'h00);
    wr(`IDX_CHANNEL, 8'h02);
    wr(`IDX_CONTROL, on_bit | go_bit);
    conv_len(n);
    check("first length", 8'(near(n, 50)), 8'h01);
    check("core_power", 8'(core_power), 8'h01);
    rd_chk("done control", `IDX_CONTROL, on_bit | flag_bit);
    rd_chk("result", `IDX_RESULT, 8'haa);
    for (int d = 0; d < 8; d++)
    begin
      wr(`IDX_CONTROL, on_bit | go_bit | flag_bit | ie_bit | 8'(d));
      conv_len(n);
      check("divided length", 8'(near(n, 13 * (d == 0 ? 2 : (1 << d)))), 8'h01);
    end
    check("irq masked", 8'(irq), 8'h00);
    global_irq_enable <= 1'b1;
    repeat (2) @(posedge hclk);
    check("irq raised", 8'(irq), 8'h01);
    irq_vector_ack <= 1'b1;
    @(posedge hclk);
    irq_vector_ack <= 1'b0;
    repeat (2) @(posedge hclk);
    check("irq after ack", 8'(irq), 8'h00);
    rd_chk("flag after ack", `IDX_CONTROL, on_bit | ie_bit | 8'h07);
    // a fresh value, not read-modify-write, so no pending flag is cleared
    wr(`IDX_CONTROL, on_bit | go_bit);
    wait_conv(1'b1, 300, n);
    wr(`IDX_CHANNEL, 8'h03);
    wr(`IDX_CONTROL, on_bit);
    check("locked channel", 8'(core_channel), 8'h02);
    rd_chk("go while busy", `IDX_CONTROL, on_bit | go_bit);
    wait_conv(1'b0, 300, n);
    repeat (2) @(posedge hclk);
    check("new channel", 8'(core_channel), 8'h03);
    rd_chk("result", `IDX_RESULT, 8'haa);
    wr(`IDX_TRIGGER, 8'h02);
    trigger_flags <= 8'h04;
    repeat (10) @(posedge hclk);
    trigger_flags <= 8'h00;
    rd_chk("auto off", `IDX_CONTROL, on_bit | flag_bit);
    wr(`IDX_CONTROL, on_bit | auto_bit | flag_bit);
    for (int t = 1; t < 8; t++)
    begin
      wr(`IDX_TRIGGER, 8'(t));
      trigger_flags <= 8'h01 << t;
      wait_conv(1'b1, 8, n);
      wait_conv(1'b0, 300, n);
      trigger_flags <= 8'h00;
      @(posedge hclk);
    end
    rd_chk("result ch3", `IDX_RESULT, 8'hff);
    wr(`IDX_TRIGGER, 8'h02);
    trigger_flags <= 8'h08;
    repeat (4) @(posedge hclk);
    check("no edge yet", 8'(core_convert), 8'h00);
    wr(`IDX_TRIGGER, 8'h03);
    wait_conv(1'b1, 8, n);
    wait_conv(1'b0, 300, n);
    trigger_flags <= 8'h00;
    wr(`IDX_TRIGGER, 8'h00);
    repeat (6) @(posedge hclk);
    check("free select", 8'(core_convert), 8'h00);
    wr(`IDX_CONTROL, on_bit | auto_bit | go_bit);
    repeat (200) @(posedge hclk);
    rd_chk("free running", `IDX_CONTROL, on_bit | auto_bit | go_bit | flag_bit);
    wr(`IDX_CONTROL, 8'h00);
    repeat (2) @(posedge hclk);
    check("abort convert", 8'(core_convert), 8'h00);
    check("abort power", 8'(core_power), 8'h00);
    end_of_test();
  end

  initial
  begin
    repeat (100000) @(posedge hclk);
    miscompares++;
    end_of_test();
  end

endmodule : tb_adc_conversion_sequencer
`default_nettype wire

//--- trigger_edge.sv
/*
  selects the auto-trigger source flag and reports its rising edge.
  assumes source flags come from logic on hclk, so no synchroniser.
*/
`include "adc_seq_defs.svh"
`default_nettype none
module trigger_edge
  import adc_seq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] flags,
  input wire logic [2:0] sel,
  input wire logic auto_on,
  output logic event_pulse
);

  edge_state_t s;
  edge_state_t next_s;
  logic selected;

  // -----------------------------------------------------------------
  // source mux and edge
  // -----------------------------------------------------------------
  always_comb
  begin
    // code 0 is free running and never yields an edge
    selected = auto_on && (sel != `TRIG_FREE_RUN) && flags[sel];
    event_pulse = selected && !s.prev;
    next_s.prev = selected;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  a_edge_once: assert property (@(posedge hclk) disable iff (!hresetn)
    event_pulse |=> !event_pulse)
    else $error("trigger edge lasted two cycles");

endmodule : trigger_edge
`default_nettype wire
